// file: rtl/fsls_pkg.sv
// Shared constants and types for the flash lock-bit and suspend sequencer controller
package fsls_pkg;
  // Flash command bytes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_BLOCK_LOCK = 8'h01;
  localparam logic [7:0] CMD_PERM_LOCK = 8'hF1;
  // Flash status bit positions
  localparam int SR_READY = 7;
  localparam int SR_ERASE_CLR_ERR = 5;
  localparam int SR_PROG_SET_ERR = 4;
  localparam int SR_SUPPLY_ERR = 3;
  localparam int SR_SUSPENDED = 2;
  localparam int SR_PROTECT = 1;
  // Wishbone register byte addresses
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_RESULT = 5'h08;
  localparam logic [4:0] REG_IRQ_STAT = 5'h0C;
  localparam logic [4:0] REG_IRQ_CLR = 5'h10;
  localparam logic [4:0] REG_IRQ_EN = 5'h14;
  // Operation codes written to CTRL[2:0]; CTRL[3] starts the operation
  localparam logic [2:0] OP_SUSPEND = 3'h0;
  localparam logic [2:0] OP_RESUME = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_BLOCK_LOCK = 3'h3;
  localparam logic [2:0] OP_PERM_LOCK = 3'h4;
  localparam logic [2:0] OP_CLEAR_LOCKS = 3'h5;
  localparam logic [2:0] OP_CLEAR_STATUS = 3'h6;
  localparam logic [2:0] OP_RESET = 3'h7;
  localparam int CTRL_GO = 3;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_READY_RISE = 2;
  localparam int IRQ_W = 3;
  // Bus cycle timing
  localparam int CLK_MHZ = 50;
  localparam int T_PULSE_NS = 60;
  localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RESET_NS = 100;
  localparam int RESET_CYC = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int ADDR_W = 21;
  // One flash bus transaction request
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fsls_req_t;
  // Flash pin outputs
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dq;
  } fsls_pins_t;
endpackage

// file: rtl/fsls_sync.sv
// Two flip-flop synchroniser for an asynchronous level
module fsls_sync #(
  parameter int W = 1
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [W-1:0] d_i, // Asynchronous input
  output logic [W-1:0] q_o // Synchronised output
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// file: rtl/fsls_ctrl.sv
// Host controller sequencing suspend, resume, read and lock-bit commands to a parallel flash
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
module fsls_ctrl #(
  parameter int ADDR_W = fsls_pkg::ADDR_W
) (
  input wire logic clk_i, // Clock, 50 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [4:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic irq_o, // Level interrupt
  output logic [ADDR_W-1:0] flash_addr_o, // Flash address
  output logic [7:0] flash_dq_o, // Flash data out
  output logic flash_dq_oe_o, // Flash data drive enable
  input wire logic [7:0] flash_dq_i, // Flash data in
  output logic flash_ce_n_o, // Flash chip enable, active low
  output logic flash_oe_n_o, // Flash output enable, active low
  output logic flash_we_n_o, // Flash write enable, active low
  output logic reset_powerdown_n_o, // Flash reset, active low
  input wire logic ready_busy_n_i, // Ready/busy pin, pulled up
  output logic busy_o // Sequencer busy
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_RESET, ST_PRE_STAT, ST_PRE_POLL, ST_CMD1, ST_CMD2,
    ST_POLL, ST_READ, ST_FINAL, ST_DONE
  } fsls_state_t;

  fsls_state_t state_r, state_nxt;
  fsls_pkg::fsls_req_t req_r;
  logic [3:0] bus_cnt_r;
  logic bus_act_r;
  logic [7:0] rd_data_r;
  logic [2:0] op_r;
  logic [ADDR_W-1:0] tgt_addr_r;
  logic [7:0] result_r;
  logic suspended_r;
  logic [fsls_pkg::IRQ_W-1:0] irq_stat_r, irq_en_r;
  logic [7:0] dq_s;
  logic busy_pin_s, rb_prev_r;
  logic [7:0] step_r;

  // Pins arrive asynchronously
  fsls_sync #(.W(9)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({~ready_busy_n_i, flash_dq_i}),
    .q_o({busy_pin_s, dq_s})
  );
  // Synced inverted so the cleared flops match the pulled-up idle level: no false rise after reset
  wire rb_s = !busy_pin_s;

  // Wishbone decode
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  wire wr_ctrl = wb_wr && wb_adr_i == fsls_pkg::REG_CTRL;
  wire wr_addr = wb_wr && wb_adr_i == fsls_pkg::REG_ADDR;
  wire wr_clr = wb_wr && wb_adr_i == fsls_pkg::REG_IRQ_CLR;
  wire wr_en = wb_wr && wb_adr_i == fsls_pkg::REG_IRQ_EN;
  wire start = wr_ctrl && wb_dat_i[fsls_pkg::CTRL_GO] && state_r == ST_IDLE;
  wire [31:0] rd_mux =
    wb_adr_i == fsls_pkg::REG_CTRL ? {28'h0, busy_o, op_r} :
    wb_adr_i == fsls_pkg::REG_ADDR ? {{(32-ADDR_W){1'b0}}, tgt_addr_r} :
    wb_adr_i == fsls_pkg::REG_RESULT ? {22'h0, suspended_r, rb_s, rd_data_r} :
    wb_adr_i == fsls_pkg::REG_IRQ_STAT ? {29'h0, irq_stat_r} :
    wb_adr_i == fsls_pkg::REG_IRQ_EN ? {29'h0, irq_en_r} : 32'h0;

  // Bus engine: one flash cycle with strobe low for PULSE_CYC clocks
  wire bus_done = bus_act_r && bus_cnt_r == 4'(fsls_pkg::PULSE_CYC);
  logic issue;
  fsls_pkg::fsls_req_t issue_req;
  wire rdy = rd_data_r[fsls_pkg::SR_READY];
  wire err_any = rd_data_r[fsls_pkg::SR_ERASE_CLR_ERR] | rd_data_r[fsls_pkg::SR_PROG_SET_ERR] |
    rd_data_r[fsls_pkg::SR_SUPPLY_ERR] | rd_data_r[fsls_pkg::SR_PROTECT];
  wire is_lock = op_r == fsls_pkg::OP_BLOCK_LOCK || op_r == fsls_pkg::OP_PERM_LOCK ||
    op_r == fsls_pkg::OP_CLEAR_LOCKS;
  wire rst_done = state_r == ST_RESET && bus_cnt_r == 4'(fsls_pkg::RESET_CYC);

  // Command bytes for each operation
  logic [7:0] cmd1, cmd2;
  logic [ADDR_W-1:0] addr2;
  always_comb
  begin
    cmd1 = fsls_pkg::CMD_LOCK_SETUP;
    cmd2 = fsls_pkg::CMD_CONFIRM;
    addr2 = '0;
    unique case (op_r)
      fsls_pkg::OP_SUSPEND: cmd1 = fsls_pkg::CMD_SUSPEND;
      fsls_pkg::OP_RESUME: cmd1 = fsls_pkg::CMD_CONFIRM;
      fsls_pkg::OP_READ: cmd1 = fsls_pkg::CMD_READ_ARRAY;
      fsls_pkg::OP_BLOCK_LOCK:
      begin
        cmd2 = fsls_pkg::CMD_BLOCK_LOCK;
        addr2 = tgt_addr_r;
      end
      fsls_pkg::OP_PERM_LOCK: cmd2 = fsls_pkg::CMD_PERM_LOCK;
      fsls_pkg::OP_CLEAR_LOCKS: cmd2 = fsls_pkg::CMD_CONFIRM;
      fsls_pkg::OP_CLEAR_STATUS: cmd1 = fsls_pkg::CMD_CLEAR_STATUS;
      fsls_pkg::OP_RESET: cmd1 = fsls_pkg::CMD_READ_ARRAY;
    endcase
  end

  wire two_byte = is_lock;
  wire polls = op_r != fsls_pkg::OP_READ && op_r != fsls_pkg::OP_CLEAR_STATUS &&
    op_r != fsls_pkg::OP_RESUME;

  always_comb
  begin
    state_nxt = state_r;
    issue = 1'b0;
    issue_req = '0;
    unique case (state_r)
      ST_IDLE:
        if (start)
          state_nxt = wb_dat_i[2:0] == fsls_pkg::OP_RESET ? ST_RESET :
            (wb_dat_i[2:0] == fsls_pkg::OP_SUSPEND || wb_dat_i[2:0] == fsls_pkg::OP_RESUME ||
             wb_dat_i[2:0] == fsls_pkg::OP_READ) ? ST_CMD1 : ST_PRE_STAT;
      ST_RESET:
        if (rst_done)
          state_nxt = ST_DONE;
      ST_PRE_STAT:
      begin
        issue = !bus_act_r;
        issue_req = '{wr: 1'b1, addr: '0, data: fsls_pkg::CMD_READ_STATUS};
        if (bus_done)
          state_nxt = ST_PRE_POLL;
      end
      ST_PRE_POLL:
      begin
        issue = !bus_act_r;
        issue_req = '{wr: 1'b0, addr: '0, data: 8'h00};
        if (bus_done && dq_s[fsls_pkg::SR_READY])
          state_nxt = ST_CMD1;
      end
      ST_CMD1:
      begin
        issue = !bus_act_r;
        issue_req = '{wr: 1'b1, addr: '0, data: cmd1};
        if (bus_done)
          state_nxt = two_byte ? ST_CMD2 : op_r == fsls_pkg::OP_READ ? ST_READ : polls ? ST_POLL : ST_DONE;
      end
      ST_CMD2:
      begin
        issue = !bus_act_r;
        issue_req = '{wr: 1'b1, addr: addr2, data: cmd2};
        if (bus_done)
          state_nxt = ST_POLL;
      end
      ST_POLL:
      begin
        issue = !bus_act_r;
        issue_req = '{wr: 1'b0, addr: '0, data: 8'h00};
        if (bus_done && dq_s[fsls_pkg::SR_READY])
          state_nxt = is_lock ? ST_FINAL : ST_DONE;
      end
      ST_READ:
      begin
        issue = !bus_act_r;
        issue_req = '{wr: 1'b0, addr: tgt_addr_r, data: 8'h00};
        if (bus_done)
          state_nxt = ST_DONE;
      end
      ST_FINAL:
      begin
        issue = !bus_act_r;
        issue_req = '{wr: 1'b1, addr: '0, data: fsls_pkg::CMD_READ_ARRAY};
        if (bus_done)
          state_nxt = ST_DONE;
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Latch the polled status; error bits come from the device's sticky status
  wire poll_hit = bus_done && !req_r.wr;
  wire suspend_seen = poll_hit && state_r == ST_POLL && op_r == fsls_pkg::OP_SUSPEND &&
    dq_s[fsls_pkg::SR_READY];
  wire seq_err = rd_data_r[fsls_pkg::SR_ERASE_CLR_ERR] & rd_data_r[fsls_pkg::SR_PROG_SET_ERR];
  wire done_ev = state_r == ST_DONE;
  wire err_ev = done_ev && (err_any || seq_err) && op_r != fsls_pkg::OP_CLEAR_STATUS;
  wire rise_ev = rb_s && !rb_prev_r;
  wire [fsls_pkg::IRQ_W-1:0] ev = {rise_ev, err_ev, done_ev};
  wire [fsls_pkg::IRQ_W-1:0] clr_bits = wr_clr ? wb_dat_i[fsls_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      bus_act_r <= 1'b0;
      bus_cnt_r <= '0;
      req_r <= '0;
      rd_data_r <= '0;
      op_r <= '0;
      tgt_addr_r <= '0;
      suspended_r <= 1'b0;
      irq_stat_r <= '0;
      irq_en_r <= '0;
      rb_prev_r <= 1'b1;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      rb_prev_r <= rb_s;
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : wb_dat_o;
      if (start)
        op_r <= wb_dat_i[2:0];
      if (wr_addr)
        tgt_addr_r <= wb_dat_i[ADDR_W-1:0];
      if (wr_en)
        irq_en_r <= wb_dat_i[fsls_pkg::IRQ_W-1:0];
      irq_stat_r <= (irq_stat_r & ~clr_bits) | ev; // Set wins over clear
      if (start && wb_dat_i[2:0] == fsls_pkg::OP_RESET)
        suspended_r <= 1'b0;
      else if (suspend_seen)
        suspended_r <= dq_s[fsls_pkg::SR_SUSPENDED];
      else if (state_r == ST_CMD1 && bus_done && op_r == fsls_pkg::OP_RESUME)
        suspended_r <= 1'b0;
      if (issue)
      begin
        req_r <= issue_req;
        bus_act_r <= 1'b1;
        bus_cnt_r <= '0;
      end
      else if (bus_done)
        bus_act_r <= 1'b0;
      else if (bus_act_r || state_r == ST_RESET)
        bus_cnt_r <= bus_cnt_r + 4'h1;
      else
        bus_cnt_r <= '0;
      if (poll_hit)
        rd_data_r <= dq_s;
      else if (rst_done)
        rd_data_r <= '0;
    end
  end

  // Pin registers
  wire strobe = bus_act_r && !bus_done;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flash_addr_o <= '0;
      flash_dq_o <= '0;
      flash_dq_oe_o <= 1'b0;
      flash_ce_n_o <= 1'b1;
      flash_oe_n_o <= 1'b1;
      flash_we_n_o <= 1'b1;
      reset_powerdown_n_o <= 1'b0;
      irq_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      flash_addr_o <= req_r.addr;
      flash_dq_o <= req_r.data;
      flash_dq_oe_o <= bus_act_r && req_r.wr;
      flash_ce_n_o <= !strobe;
      flash_oe_n_o <= !(strobe && !req_r.wr);
      flash_we_n_o <= !(strobe && req_r.wr);
      reset_powerdown_n_o <= state_nxt != ST_RESET;
      irq_o <= |(irq_stat_r & irq_en_r);
      busy_o <= state_nxt != ST_IDLE;
    end
  end
endmodule

// file: sim/fsls_chk.sv
// Port checker for the flash sequencer controller
module fsls_chk #(
  parameter int ADDR_W = 21
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Ack
  input wire logic flash_ce_n_o, // Chip enable
  input wire logic flash_oe_n_o, // Output enable
  input wire logic flash_we_n_o, // Write enable
  input wire logic flash_dq_oe_o, // Data drive
  input wire logic [ADDR_W-1:0] flash_addr_o, // Address
  input wire logic [7:0] flash_dq_o, // Data
  input wire logic reset_powerdown_n_o, // Flash reset
  input wire logic busy_o // Busy
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  AST_RST_OUT: assert property ($fell(rst_i) |-> !reset_powerdown_n_o && flash_ce_n_o && !busy_o)
    else $error("outputs after reset");
  AST_WE_LEN: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o [*3] ##1 flash_we_n_o)
    else $error("write strobe length");
  AST_WE_DRV: assert property (!flash_we_n_o |-> flash_dq_oe_o && !flash_ce_n_o && flash_oe_n_o)
    else $error("write cycle drive");
  AST_RD_FREE: assert property (!flash_oe_n_o |-> !flash_dq_oe_o && !flash_ce_n_o)
    else $error("read cycle contention");
  AST_HOLD: assert property (!flash_we_n_o && !$fell(flash_we_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o))
    else $error("write data moved");
  AST_GAP: assert property ($rose(flash_ce_n_o) |-> flash_we_n_o && flash_oe_n_o)
    else $error("strobe left low");
  AST_PD_PULSE: assert property ($fell(reset_powerdown_n_o) |-> (!reset_powerdown_n_o && flash_ce_n_o) [*5])
    else $error("flash reset pulse");
  cover property ($fell(flash_we_n_o));
  cover property ($fell(flash_oe_n_o));
  cover property ($fell(reset_powerdown_n_o));
endmodule
bind fsls_ctrl fsls_chk #(.ADDR_W(ADDR_W)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o),
  .flash_we_n_o(flash_we_n_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_addr_o(flash_addr_o),
  .flash_dq_o(flash_dq_o), .reset_powerdown_n_o(reset_powerdown_n_o), .busy_o(busy_o));

// file: sim/fsls_flash_model.sv
// Behavioural flash: command interface, status and ready/busy
module fsls_flash_model (
  input wire logic clk_i, // Clock
  input wire logic reset_powerdown_n_i, // Reset, active low
  input wire logic ce_n_i, // Chip enable
  input wire logic oe_n_i, // Output enable
  input wire logic we_n_i, // Write enable
  input wire logic [20:0] addr_i, // Address
  input wire logic [7:0] dq_i, // Data in
  output logic [7:0] dq_o, // Data out
  output logic ready_busy_n_o // Ready/busy
);
  logic [7:0] sr_r, cmd_r, last_r;
  logic [20:0] adr_r, lock_r;
  logic we_q, stat_r, setup_r, susp_r;
  logic perm_r = 1'b0, wr_r = 1'b0, bad_r = 1'b0, fail_r = 1'b0;
  int left_r = 0;
  wire rdy = left_r == 0 || susp_r;
  wire rd = !ce_n_i && !oe_n_i;
  // Released bus shows the inverse so stale data never passes
  assign dq_o = rd ? (stat_r ? {rdy, sr_r[6:0]} : addr_i[7:0] ^ 8'h5A) : ~last_r;
  assign ready_busy_n_o = rdy;
  always @(posedge clk_i)
  begin
    we_q <= we_n_i;
    if (rd) last_r <= dq_o;
    if (!we_n_i && !ce_n_i) {cmd_r, adr_r} <= {dq_i, addr_i};
    if (!reset_powerdown_n_i) {sr_r, stat_r, setup_r, susp_r, left_r} <= '0;
    else if (we_n_i && !we_q)
    begin
      stat_r <= 1'b1;
      setup_r <= 1'b0;
      if (setup_r && cmd_r inside {8'h01, 8'hF1, 8'hD0})
      begin
        left_r <= 4;
        if (cmd_r == 8'h01) lock_r <= adr_r;
        if (perm_r && cmd_r != 8'hF1) sr_r[1] <= 1'b1;
        else
        begin
          if (bad_r || fail_r) sr_r[cmd_r == 8'hD0 ? 5 : 4] <= 1'b1;
          if (bad_r) sr_r[3] <= 1'b1;
          if (cmd_r == 8'hF1 && !bad_r && !fail_r) perm_r <= 1'b1;
        end
      end
      else if (setup_r) sr_r[5:4] <= 2'b11;
      else case (cmd_r)
        8'hFF: stat_r <= 1'b0;
        8'h60: setup_r <= 1'b1;
        8'h50: {sr_r[5:3], sr_r[1]} <= 4'h0;
        8'hB0: {susp_r, sr_r[2]} <= {2{left_r != 0 && wr_r}};
        8'hD0: {susp_r, sr_r[2]} <= 2'b00;
        default: ;
      endcase
    end
    else if (left_r != 0 && !susp_r) left_r <= left_r - 1;
  end
endmodule

// file: sim/tb.sv
// Self-checking bench for the flash sequencer controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat = 32'h0, rd;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq_o, foe, ce_n, oe_n, we_n, flash_rst_n, flash_rb_n, busy_o;
  logic [20:0] fa;
  logic [7:0] fdo, fdm;
  wire [7:0] bus = foe ? fdo : fdm;
  int failures = 0, check_count = 0, cycles = 0;
  fsls_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .flash_addr_o(fa), .flash_dq_o(fdo), .flash_dq_oe_o(foe), .flash_dq_i(bus),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .reset_powerdown_n_o(flash_rst_n),
    .ready_busy_n_i(flash_rb_n), .busy_o(busy_o));
  fsls_flash_model flash_u (.clk_i(clk_i), .reset_powerdown_n_i(flash_rst_n), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .addr_i(fa), .dq_i(bus), .dq_o(fdm), .ready_busy_n_o(flash_rb_n));
  always #10 clk_i = ~clk_i;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits have no local limit: only the global cycle ceiling ends a hang
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic op(input logic [2:0] o);
    wb(1'b1, fsls_pkg::REG_CTRL, {28'h0, 1'b1, o});
    do wb(1'b0, fsls_pkg::REG_CTRL, 32'h0); while (rd[3] !== 1'b0);
  endtask
  task automatic res(input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, fsls_pkg::REG_RESULT, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic t_regs();
    wb(1'b0, fsls_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, fsls_pkg::REG_IRQ_EN, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 5'h1C, 32'hFF);
    wb(1'b0, 5'h1C, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
  endtask
  task automatic t_suspend();
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk_i);
      flash_u.wr_r = 1'b1;
      flash_u.left_r = k ? 0 : 300;
      op(fsls_pkg::OP_SUSPEND);
      res(32'h3FF, k ? 32'h180 : 32'h384);
      wb(1'b1, fsls_pkg::REG_ADDR, 32'h00123);
      op(fsls_pkg::OP_READ);
      res(32'hFF, 32'h79);
      op(fsls_pkg::OP_RESUME);
      chk({31'h0, flash_rb_n}, {31'h0, k[0]});
      op(fsls_pkg::OP_CLEAR_STATUS);
      res(32'hFF, 32'h80);
    end
    $display("suspend test done");
  endtask
  task automatic t_lock();
    wb(1'b1, fsls_pkg::REG_IRQ_EN, 32'h0);
    wb(1'b1, fsls_pkg::REG_ADDR, 32'h1F000);
    flash_u.bad_r = 1'b1;
    op(fsls_pkg::OP_BLOCK_LOCK);
    res(32'hFF, 32'h98);
    chk({11'h0, flash_u.lock_r}, 32'h1F000);
    chk({31'h0, flash_u.stat_r}, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wb(1'b1, fsls_pkg::REG_IRQ_EN, 32'h2);
    // Interrupt output is registered one edge behind the enable
    @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, fsls_pkg::REG_IRQ_CLR, 32'h7);
    wb(1'b0, fsls_pkg::REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    {flash_u.bad_r, flash_u.fail_r} = 2'b01;
    op(fsls_pkg::OP_BLOCK_LOCK);
    res(32'hFF, 32'h98);
    op(fsls_pkg::OP_CLEAR_STATUS);
    op(fsls_pkg::OP_CLEAR_LOCKS);
    op(fsls_pkg::OP_CLEAR_STATUS);
    res(32'hFF, 32'hA0);
    flash_u.fail_r = 1'b0;
    op(fsls_pkg::OP_PERM_LOCK);
    op(fsls_pkg::OP_BLOCK_LOCK);
    res(32'hFF, 32'h82);
    op(fsls_pkg::OP_RESET);
    op(fsls_pkg::OP_CLEAR_STATUS);
    res(32'hFF, 32'h80);
    op(fsls_pkg::OP_CLEAR_LOCKS);
    op(fsls_pkg::OP_CLEAR_STATUS);
    res(32'hFF, 32'h82);
    $display("lock test done");
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_suspend();
    t_lock();
    print_verdict();
  end
endmodule
